//--- mps_port.sv
// mgmt serial port: mdio frame engine, strap address, interrupt, options
`timescale 1ns/10ps
`include "mps_map.svh"
module mps_port (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq,
    input  wire logic        i_mdc,
    input  wire logic        i_mdio,
    output logic             o_mdio,
    output logic             o_mdio_oe,
    input  wire logic [4:0]  i_addr_strap_pins,
    output logic             o_mgmt_interrupt_n,
    output logic             o_mgmt_interrupt_n_oe,
    output logic      [3:0]  o_prog_led_outputs,
    output logic      [3:0]  o_prog_led_outputs_oe,
    input  wire logic [14:0] i_status_bits,
    input  wire logic        i_rx_activity,
    input  wire logic        i_rxen_or_backpressure_pin,
    input  wire logic [3:0]  i_txd,
    output logic             o_tx_clk,
    output logic      [3:0]  o_txd,
    output logic             o_squelch_adj,
    output logic             o_jam_tx,
    output logic             o_rx_out_en
);
    import mps_pkg::*;

    logic [7:0]  sync_q;
    logic        mdc_s, mdio_s, rj_pin_s, mdc_prev_reg, mdc_rise;
    logic [4:0]  strap_s, phy_addr_reg;
    logic [8:0]  por_cnt_reg;
    logic        por_done_reg;
    logic [15:0] ctrl_reg, mask_reg, cfg1_reg, cfg2_reg;
    logic [14:0] snap_reg, changed;
    logic        int_now, int_prev_reg, int_rise;
    mps_state_t  state_reg;
    logic [4:0]  cnt_reg, ra_reg, load_addr;
    logic [5:0]  pre_reg;
    logic [11:0] hdr_reg, hdr_full;
    logic        op_rd_reg, multi_reg, hdr_ok;
    logic [15:0] sh_reg, wr_data, load_val;
    logic        load_first, last_bit, go_next, stat_load, wr_fire;
    logic [1:0]  evt_reg, evt_mask_reg;
    logic        apb_fire;
    mps_apb_sel_t apb_sel;

    // pins from outside pass two flops first
    mps_sync #(.WIDTH(8)) u_sync (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_d    ({i_rxen_or_backpressure_pin, i_addr_strap_pins,
                  i_mdio, i_mdc}),
        .o_q    (sync_q)
    );
    assign mdc_s    = sync_q[0];
    assign mdio_s   = sync_q[1];
    assign strap_s  = sync_q[6:2];
    assign rj_pin_s = sync_q[7];
    assign mdc_rise = mdc_s & ~mdc_prev_reg;

    function automatic logic [15:0] rd_val(input logic [4:0] a);
        unique case (a)
            `MPS_REG_CTRL: rd_val = ctrl_reg;
            `MPS_REG_STAT: rd_val = {int_now, i_status_bits};
            `MPS_REG_MASK: rd_val = mask_reg;
            `MPS_REG_CFG1: rd_val = cfg1_reg;
            `MPS_REG_CFG2: rd_val = cfg2_reg;
            default:       rd_val = 16'h0000;
        endcase
    endfunction

    function automatic mps_apb_sel_t apb_dec(input logic [11:0] a);
        unique case (a)
            `MPS_APB_EVT:  apb_dec = 2'h0;
            `MPS_APB_MASK: apb_dec = 2'h1;
            `MPS_APB_INFO: apb_dec = 2'h2;
            default:       apb_dec = 2'h3;
        endcase
    endfunction

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mdc_prev_reg <= 1'b0;
        end else begin
            mdc_prev_reg <= mdc_s;
        end
    end

    // pins float for the whole por interval, address taken at its end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            por_cnt_reg  <= 9'h000;
            por_done_reg <= 1'b0;
            phy_addr_reg <= 5'h00;
        end else if (!por_done_reg) begin
            por_cnt_reg <= por_cnt_reg + 9'h001;
            if (por_cnt_reg == 9'(`MPS_POR_CYC - 1)) begin
                por_done_reg <= 1'b1;
                phy_addr_reg <= ~strap_s;
            end
        end
    end

    // status change against the snapshot of the last read
    assign changed  = (i_status_bits ^ snap_reg) & ~mask_reg[14:0];
    assign int_now  = |changed;
    assign int_rise = int_now & ~int_prev_reg;

    assign hdr_full   = {hdr_reg[10:0], mdio_s};
    assign hdr_ok     = por_done_reg && (hdr_full[9:5] == phy_addr_reg) &&
                        (hdr_full[11:10] == `MPS_OP_RD ||
                         hdr_full[11:10] == `MPS_OP_WR);
    assign load_first = mdc_rise && state_reg == MPS_TA && cnt_reg == 5'h01;
    assign last_bit   = mdc_rise && state_reg == MPS_DATA &&
                        cnt_reg == 5'h0F;
    // multiple access stops after the last register so mdio is released
    assign go_next    = last_bit && multi_reg && ra_reg < `MPS_LAST_REG;
    assign load_addr  = load_first ? ra_reg : ra_reg + 5'h01;
    // always_comb so register and status changes reach the loaded word
    always_comb load_val = rd_val(load_addr);
    assign stat_load  = op_rd_reg && (load_first || go_next) &&
                        load_addr == `MPS_REG_STAT;
    assign wr_data    = {sh_reg[14:0], mdio_s};
    assign wr_fire    = last_bit && !op_rd_reg;

    // frame engine, sampled on rising mdc only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= MPS_IDLE;
            cnt_reg   <= 5'h00;
            pre_reg   <= 6'h00;
            hdr_reg   <= 12'h000;
            op_rd_reg <= 1'b0;
            multi_reg <= 1'b0;
            ra_reg    <= 5'h00;
            sh_reg    <= 16'h0000;
            o_mdio    <= 1'b0;
            o_mdio_oe <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state_reg)
                MPS_IDLE: begin
                    o_mdio_oe <= 1'b0;
                    if (mdio_s) begin
                        if (pre_reg != `MPS_PRE_LEN) begin
                            pre_reg <= pre_reg + 6'h01;
                        end
                    end else begin
                        if (pre_reg == `MPS_PRE_LEN) begin
                            state_reg <= MPS_START;
                        end
                        pre_reg <= 6'h00;
                    end
                end
                MPS_START: begin
                    state_reg <= mdio_s ? MPS_HDR : MPS_IDLE;
                    cnt_reg   <= 5'h00;
                end
                MPS_HDR: begin
                    hdr_reg <= hdr_full;
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == 5'h0B) begin
                        cnt_reg   <= 5'h00;
                        state_reg <= hdr_ok ? MPS_TA : MPS_IDLE;
                        op_rd_reg <= hdr_full[11:10] == `MPS_OP_RD;
                        multi_reg <= cfg2_reg[`MPS_CFG2_MRA] &&
                                     hdr_full[4:0] == `MPS_ALL_REGS;
                        ra_reg    <= (cfg2_reg[`MPS_CFG2_MRA] &&
                                      hdr_full[4:0] == `MPS_ALL_REGS) ?
                                     5'h00 : hdr_full[4:0];
                    end
                end
                MPS_TA: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == 5'h00) begin
                        o_mdio    <= 1'b0;
                        o_mdio_oe <= op_rd_reg;
                    end else begin
                        state_reg <= MPS_DATA;
                        cnt_reg   <= 5'h00;
                        sh_reg    <= load_val;
                        o_mdio    <= load_val[15];
                    end
                end
                MPS_DATA: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (op_rd_reg) begin
                        sh_reg <= {sh_reg[14:0], 1'b0};
                        o_mdio <= sh_reg[14];
                    end else begin
                        sh_reg <= wr_data;
                    end
                    if (go_next) begin
                        ra_reg  <= ra_reg + 5'h01;
                        cnt_reg <= 5'h00;
                        sh_reg  <= op_rd_reg ? load_val : 16'h0000;
                        o_mdio  <= load_val[15];
                    end else if (last_bit) begin
                        state_reg <= MPS_IDLE;
                        o_mdio_oe <= 1'b0;
                    end
                end
            endcase
        end else if (state_reg == MPS_IDLE) begin
            // one-clock low pulse on an idle line signals a change
            o_mdio    <= 1'b0;
            o_mdio_oe <= int_rise && por_done_reg;
        end
    end

    // mdio side registers; multiple access starts off
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg <= 16'h0000;
            mask_reg <= 16'h0000;
            cfg1_reg <= 16'h0000;
            cfg2_reg <= 16'h0000;
        end else if (wr_fire) begin
            unique case (ra_reg)
                `MPS_REG_CTRL: ctrl_reg <= wr_data;
                `MPS_REG_MASK: mask_reg <= wr_data;
                `MPS_REG_CFG1: cfg1_reg <= wr_data;
                `MPS_REG_CFG2: cfg2_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // a status read takes the snapshot, dropping every indication
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            snap_reg     <= 15'h0000;
            int_prev_reg <= 1'b0;
        end else begin
            int_prev_reg <= int_now;
            if (stat_load) begin
                snap_reg <= i_status_bits;
            end
        end
    end

    // shared pins: open drain, only pull low, nothing during por
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mgmt_interrupt_n    <= 1'b1;
            o_mgmt_interrupt_n_oe <= 1'b0;
            o_prog_led_outputs    <= 4'hF;
            o_prog_led_outputs_oe <= 4'h0;
        end else begin
            o_mgmt_interrupt_n    <= ~int_now;
            o_mgmt_interrupt_n_oe <= por_done_reg & int_now;
            o_prog_led_outputs    <= 4'h0;
            o_prog_led_outputs_oe <= por_done_reg ?
                                     cfg2_reg[`MPS_CFG2_LED] : 4'h0;
        end
    end

    // config side effects and the derived transmit clock
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_squelch_adj <= 1'b0;
            o_jam_tx      <= 1'b0;
            o_rx_out_en   <= 1'b0;
            o_tx_clk      <= 1'b0;
            o_txd         <= 4'h0;
        end else begin
            o_squelch_adj <= cfg1_reg[`MPS_CFG1_RLA];
            o_jam_tx      <= !cfg2_reg[`MPS_CFG2_RJ] && rj_pin_s &&
                             i_rx_activity;
            o_rx_out_en   <= cfg2_reg[`MPS_CFG2_RJ] ? rj_pin_s : 1'b1;
            o_tx_clk      <= ~o_tx_clk;
            if (!o_tx_clk) begin
                o_txd <= i_txd;
            end
        end
    end

    // apb slave, one wait state; events sticky, write one to clear
    assign apb_sel  = apb_dec(i_paddr);
    assign apb_fire = i_psel && i_penable && o_pready;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready     <= 1'b0;
            o_pslverr    <= 1'b0;
            o_prdata     <= 32'h0000_0000;
            evt_reg      <= 2'h0;
            evt_mask_reg <= 2'h0;
            o_irq        <= 1'b0;
        end else begin
            o_pready  <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready &&
                         apb_sel == 2'h3;
            if (i_psel && i_penable && !o_pready) begin
                unique case (apb_sel)
                    2'h0: o_prdata <= {30'h0, evt_reg};
                    2'h1: o_prdata <= {30'h0, evt_mask_reg};
                    2'h2: o_prdata <= {21'h0, phy_addr_reg, int_now,
                                       cfg2_reg[`MPS_CFG2_RJ],
                                       cfg2_reg[`MPS_CFG2_MRA],
                                       cfg1_reg[`MPS_CFG1_RLA],
                                       por_done_reg, multi_reg};
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
            if (apb_fire && i_pwrite && apb_sel == 2'h1) begin
                evt_mask_reg <= i_pwdata[1:0];
            end
            // set beats a clear in the same cycle
            evt_reg <= (evt_reg &
                        ~((apb_fire && i_pwrite && apb_sel == 2'h0) ?
                          i_pwdata[1:0] : 2'h0)) |
                       {int_rise, wr_fire};
            o_irq <= |(evt_reg & evt_mask_reg);
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    chk_strap_invert: assert property (
        $rose(por_done_reg) |-> phy_addr_reg == ~$past(strap_s))
        else $error("latched address is not the inverted strap");
    chk_por_float: assert property (
        !por_done_reg |=> !o_mgmt_interrupt_n_oe &&
                          o_prog_led_outputs_oe == 4'h0)
        else $error("shared pin driven during por");
    chk_int_pin: assert property (
        por_done_reg && int_now |=> o_mgmt_interrupt_n_oe &&
                                    !o_mgmt_interrupt_n)
        else $error("interrupt pin not low on change");
    chk_read_clears: assert property (
        stat_load && $stable(i_status_bits) ##1 $stable(i_status_bits)
        |-> !int_now)
        else $error("interrupt survives status read");
    chk_multi_gate: assert property (
        $rose(multi_reg) |-> $past(cfg2_reg[`MPS_CFG2_MRA]))
        else $error("multiple access without enable");
    chk_multi_order: assert property (
        go_next |=> ra_reg == $past(ra_reg) + 5'h01 && cnt_reg == 5'h00)
        else $error("multiple access not ascending");
    chk_ta_drive: assert property (
        load_first && op_rd_reg |-> o_mdio_oe && !o_mdio
        ##1 o_mdio == $past(load_val[15]))
        else $error("turnaround or first data bit wrong");
    chk_jam_gate: assert property (
        o_jam_tx |-> $past(!cfg2_reg[`MPS_CFG2_RJ] && rj_pin_s))
        else $error("jam sent without selection");
    chk_int_mask: assert property (
        ((i_status_bits ^ snap_reg) & ~mask_reg[14:0]) == 15'h0000
        |=> o_mgmt_interrupt_n && !o_mgmt_interrupt_n_oe)
        else $error("masked change raised interrupt");
endmodule // mps_port

//--- mps_map.svh
// register map, field positions and timing counts of the mgmt serial port
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH
`define MPS_CLK_NS   100
`define MPS_POR_NS   20000
`define MPS_POR_CYC  ((`MPS_POR_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
`define MPS_PRE_LEN  6'h20
`define MPS_OP_RD    2'h2
`define MPS_OP_WR    2'h1
`define MPS_ALL_REGS 5'h1F
`define MPS_LAST_REG 5'h04
`define MPS_REG_CTRL 5'h00
`define MPS_REG_STAT 5'h01
`define MPS_REG_MASK 5'h02
`define MPS_REG_CFG1 5'h03
`define MPS_REG_CFG2 5'h04
`define MPS_STAT_INT 15
`define MPS_CFG1_RLA 0
`define MPS_CFG2_MRA 0
`define MPS_CFG2_RJ  1
`define MPS_CFG2_LED 5:2
`define MPS_APB_EVT  12'h000
`define MPS_APB_MASK 12'h004
`define MPS_APB_INFO 12'h008
`define MPS_EVT_WR   0
`define MPS_EVT_INT  1
`endif

//--- mps_pkg.sv
// types of the mgmt serial port
package mps_pkg;
    typedef enum logic [2:0] {
        MPS_IDLE, MPS_START, MPS_HDR, MPS_TA, MPS_DATA
    } mps_state_t;
    typedef logic [1:0] mps_apb_sel_t;
endpackage

//--- mps_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module mps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= '0;
            o_q      <= '0;
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end
endmodule // mps_sync

//--- mps_station.sv
// station manager model: mdc and mdio frame driver
`timescale 1ns/10ps
module mps_station (
    input  wire logic i_clk,
    input  wire logic i_mdio,
    output logic      o_mdc,
    output logic      o_mdio,
    output logic      o_mdio_oe,
    output logic      o_busy
);
    // four or more device clocks per half period, so eight
    localparam int HALF = 8;

    initial begin
        o_mdc     = 1'b0;
        o_mdio    = 1'b1;
        o_mdio_oe = 1'b0;
        o_busy    = 1'b0;
    end

    // one mdc period; data set while low, sampled just before the rise
    task automatic cyc(input logic drv, input logic b, output logic s);
        @(posedge i_clk);
        o_mdc     <= 1'b0;
        o_mdio    <= b;
        o_mdio_oe <= drv;
        repeat (HALF) @(posedge i_clk);
        s = i_mdio;
        o_mdc <= 1'b1;
        repeat (HALF - 1) @(posedge i_clk);
    endtask

    // only mdc and mdio are used, no interrupt pin needed
    task automatic frame(input logic rd, input logic [4:0] pa,
                         input logic [4:0] ra, input int n,
                         input logic [79:0] wd, output logic [79:0] rv);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hFFFFFFFF, 2'h1, rd ? 2'h2 : 2'h1, pa, ra};
        rv  = '0;
        o_busy <= 1'b1;
        for (int i = 45; i >= 0; i--) begin
            cyc(1'b1, hdr[i], s);
        end
        cyc(!rd, 1'b1, s); // turnaround released on reads
        cyc(!rd, 1'b0, s);
        for (int i = n - 1; i >= 0; i--) begin
            cyc(!rd, wd[i], s);
            rv = {rv[78:0], s};
        end
        @(posedge i_clk);
        o_mdc     <= 1'b0; // clock stands still between frames
        o_mdio_oe <= 1'b0;
        o_busy    <= 1'b0;
    endtask
endmodule // mps_station

//--- phy_mgmt_serial_port_bench.sv
// self-checking bench of the mgmt serial port, apb and mdio traffic
`timescale 1ns/10ps
`include "mps_map.svh"
module phy_mgmt_serial_port_bench;
    logic        i_clk   = 1'b0;
    logic        i_nrst  = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [14:0] stat    = 15'h0;
    logic        rx_act  = 1'b0;
    logic        rj_pin  = 1'b0;
    logic [3:0]  txd     = 4'h0;
    logic [31:0] seed    = 32'h06A1;
    logic [4:0]  strap   = 5'h1A; // open pins pull high, rest tied low
    logic [33:0] exp_q[$];
    logic [33:0] note;
    logic [79:0] rv;
    logic [3:0]  t_txd;
    logic        t_clk;
    int          error_cnt    = 0;
    int          total_checks = 0;
    int          pulses       = 0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, dut_md, dut_oe, int_n, int_oe;
    logic [3:0]  led, led_oe, otxd;
    logic        tx_clk, sq, jam, rxoe, mdc, st_md, st_oe, st_busy;
    wire         mdio_w = dut_oe ? dut_md : (st_oe ? st_md : 1'b1);
    wire  [4:0]  pins   = {int_oe ? int_n : strap[4],
                           (led_oe & led) | (~led_oe & strap[3:0])};

    always #50 i_clk = ~i_clk; // system supplies the reference

    mps_port uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_irq(irq), .i_mdc(mdc), .i_mdio(mdio_w),
        .o_mdio(dut_md), .o_mdio_oe(dut_oe), .i_addr_strap_pins(pins),
        .o_mgmt_interrupt_n(int_n), .o_mgmt_interrupt_n_oe(int_oe),
        .o_prog_led_outputs(led), .o_prog_led_outputs_oe(led_oe),
        .i_status_bits(stat), .i_rx_activity(rx_act),
        .i_rxen_or_backpressure_pin(rj_pin), .i_txd(txd),
        .o_tx_clk(tx_clk), .o_txd(otxd), .o_squelch_adj(sq),
        .o_jam_tx(jam), .o_rx_out_en(rxoe));

    mps_station st (.i_clk(i_clk), .i_mdio(mdio_w), .o_mdc(mdc),
        .o_mdio(st_md), .o_mdio_oe(st_oe), .o_busy(st_busy));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [79:0] v, input logic [79:0] e);
        total_checks++;
        if (v !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, v, e);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ends on a rising edge so stimulus that follows lands on it
    task automatic settle;
        repeat (4) @(posedge i_clk);
    endtask

    // expectation noted first; the monitor compares at pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic err);
        exp_q.push_back({wr, e, err});
        @(posedge i_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic mw(input logic [4:0] r, input logic [15:0] d);
        st.frame(1'b0, 5'h05, r, 16, {64'h0, d}, rv);
        settle;
    endtask

    task automatic mr(input logic [4:0] r, input int n,
                      input logic [79:0] e, input logic [4:0] pa);
        st.frame(1'b1, pa, r, n, 80'h0, rv);
        chk(rv, e);
        settle;
    endtask

    always @(posedge i_clk) begin
        if (psel && penable && pready === 1'b1) begin
            note = exp_q.pop_front();
            if (!note[33]) chk(prdata, note[32:1]);
            chk(pslverr, note[0]);
        end
    end

    // random nibbles; tx data must follow the derived tx clock
    always @(posedge i_clk) begin
        seed = xs(seed);
        txd <= seed[3:0];
        t_txd = txd;
        t_clk = tx_clk;
        #1;
        if (i_nrst && !t_clk && tx_clk === 1'b1) chk(otxd, t_txd);
        if (dut_oe === 1'b1 && dut_md === 1'b0 && !st_busy) pulses++;
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        error_cnt++;
        end_of_test;
    end

    initial begin
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        settle;
        chk({int_oe, led_oe}, 5'h00);
        repeat (205) @(posedge i_clk);
        apb(0, `MPS_APB_INFO, 0, 32'h142, 0);
        apb(0, 12'h00C, 0, 0, 1);
        mr(`MPS_REG_CFG1, 16, 80'hFFFF, 5'h1A);
        mw(`MPS_REG_CFG1, 16'h0001);
        chk(sq, 1'b1);
        apb(0, `MPS_APB_EVT, 0, 32'h1, 0);
        chk(irq, 1'b0); // a set mask bit enables its event
        apb(1, `MPS_APB_MASK, 32'h1, 0, 0);
        settle;
        chk(irq, 1'b1);
        apb(1, `MPS_APB_MASK, 32'h0, 0, 0);
        settle;
        chk(irq, 1'b0);
        apb(1, `MPS_APB_MASK, 32'h1, 0, 0);
        apb(1, `MPS_APB_EVT, 32'h1, 0, 0);
        settle;
        chk(irq, 1'b0);
        for (int k = 0; k < 4; k++) begin
            rj_pin <= k[0];
            rx_act <= 1'b1;
            mw(`MPS_REG_CFG2, {14'h0, k[1], 1'b0});
            chk(jam, !k[1] & k[0]);
            chk(rxoe, k[1] ? k[0] : 1'b1);
        end
        stat <= seed[14:0] | 15'h0001;
        settle;
        chk(int_n, 1'b0);
        chk(pulses, 1);
        mr(`MPS_REG_STAT, 16, {1'b1, stat}, 5'h05);
        chk({int_n, int_oe}, 2'h2);
        mr(`MPS_ALL_REGS, 16, 80'h0, 5'h05);
        mw(`MPS_REG_MASK, 16'h0010);
        mw(`MPS_REG_CFG2, 16'h0003);
        mr(`MPS_ALL_REGS, 80, {16'h0, 1'b0, stat, 16'h0010, 16'h0001,
           16'h0003}, 5'h05);
        stat <= stat ^ 15'h0010;
        settle;
        chk(int_n, 1'b1);
        stat <= stat ^ 15'h0001;
        settle;
        chk({int_n, pulses[1:0]}, 3'h2);
        apb(0, `MPS_APB_EVT, 0, 32'h3, 0);
        mr(`MPS_REG_STAT, 16, {1'b1, stat}, 5'h05);
        chk({int_n, int_oe}, 2'h2);
        st.frame(1'b0, 5'h05, `MPS_ALL_REGS, 80, {16'hA5C3, 16'h0000,
                 16'h0010, 16'h0001, 16'h0003}, rv);
        settle;
        mr(`MPS_REG_CTRL, 16, 80'hA5C3, 5'h05);
        end_of_test;
    end
endmodule // phy_mgmt_serial_port_bench
